//--- hw/scc_pkg.sv
package scc_pkg;
  // oscillator ticks per chopping cycle: chop = osc / 8
  localparam int          CHOP_TICKS     = 8;
  localparam int          CNT_W          = 3;
  // decay table: four entries of 3-bit switch point
  localparam int          TBL_DEPTH      = 4;
  localparam int          TBL_AW         = 2;
  localparam int          PT_W           = 3;
  localparam logic [2:0]  TBL_RST_PT     = 3'h4;
  // current monitor point: last tick of the cycle
  localparam logic [2:0]  MON_PT         = 3'h7;
  // blanking window length in core clocks
  localparam real         BLANK_NS       = 400.0;
  localparam real         CLK_NS         = 100.0;
  localparam int          BLANK_CYC      = int'(BLANK_NS / CLK_NS);
  // overcurrent non-sensitivity time in oscillator ticks
  localparam int          OC_MASK_TICKS  = 4;
  // strobe-to-restart response: one oscillator period
  localparam real         RESP_US        = 1.25;

  typedef enum logic [1:0] {
    SCC_OFF    = 2'b00,
    SCC_CHARGE = 2'b01,
    SCC_SLOW   = 2'b10,
    SCC_FAST   = 2'b11
  } scc_mode_t;

  // decay mode select
  typedef enum logic [1:0] {
    SCC_DM_SLOW  = 2'b00,
    SCC_DM_MIXED = 2'b01,
    SCC_DM_FAST  = 2'b10,
    SCC_DM_RSVD  = 2'b11
  } scc_dmode_t;
endpackage : scc_pkg

//--- hw/scc_table_mem.sv
`timescale 1ns/1ps
`default_nettype none
module scc_table_mem #(
  parameter int DEPTH = 4,
  parameter int AW    = 2,
  parameter int DW    = 3,
  parameter logic [DW-1:0] RST_VAL = '0
) (
  // clock and reset
  input  wire logic          clk_in,
  input  wire logic          rst_in,
  // write side
  input  wire logic          wr_en_in,
  input  wire logic [AW-1:0] wr_addr_in,
  input  wire logic [DW-1:0] wr_data_in,
  // read side
  input  wire logic [AW-1:0] rd_addr_in,
  output logic      [DW-1:0] rd_data_out
);
  logic [DW-1:0] mem_r [DEPTH];

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      for (int i = 0; i < DEPTH; i++) begin
        mem_r[i] <= RST_VAL;
      end
    end else if (wr_en_in) begin
      mem_r[wr_addr_in] <= wr_data_in;
    end
  end

  // registered read keeps timing clean into the decoder
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      rd_data_out <= RST_VAL;
    end else begin
      rd_data_out <= mem_r[rd_addr_in];
    end
  end
endmodule : scc_table_mem
`default_nettype wire

//--- hw/scc_chop_ctrl.sv
// Operation
// R1: chop frequency is oscillator frequency over eight
// R2: strobe clears counter at next oscillator tick
// R3: strobe response takes about one oscillator period
// R4: after strobe restart, brief charge for comparison
// R5: pure fast decay also charges briefly each cycle; the code skips it if the monitor point saw the set point
// R6: host loads table via select pin, then chops
// R7: mixed decay switches slow to fast at table point
// R8: comparator ignored during blanking after switching
// R9: overcurrent switches bridge outputs off
// R10: mixed decay sequence charge, slow, then fast
// R11: current high at monitor point skips next charge; the code does this in mixed and fast decay only, never in slow decay
// R12: counter counts ticks zero to seven, wraps
`timescale 1ns/1ps
`default_nettype none
module scc_chop_ctrl #(
  parameter int BLANK_N = scc_pkg::BLANK_CYC
) (
  // clock and reset
  input  wire logic                   core_clk_in,
  input  wire logic                   rst_in,
  // oscillator tick and host strobe
  input  wire logic                   osc_tick_in,
  input  wire logic                   strobe_in,
  // decay mode and table write
  input  wire scc_pkg::scc_dmode_t    decay_mode_in,
  input  wire logic [1:0]             decay_sel_in,
  input  wire logic                   tbl_write_sel_in,
  input  wire logic [1:0]             tbl_wr_addr_in,
  input  wire logic [2:0]             tbl_wr_data_in,
  // current sense
  input  wire logic                   set_point_reached_in,
  input  wire logic                   overcurrent_in,
  // bridge control and status
  output var scc_pkg::scc_mode_t      bridge_mode_out,
  output logic [2:0]                  chop_cnt_out,
  output logic                        overcurrent_shutdown_out
);
  import scc_pkg::*;

  logic [2:0]  cnt_r;
  logic        strobe_pend_r;
  logic        restart_r;
  logic        skip_charge_r;
  logic        charge_done_r;
  logic [2:0]  decay_switch_point;
  logic [3:0]  blank_r;
  logic [2:0]  oc_cnt_r;
  logic        oc_r;
  scc_mode_t   mode_r;
  scc_mode_t   mode_nxt;

  function automatic logic [2:0] inc3(input logic [2:0] v);
    inc3 = v + 3'h1;
  endfunction : inc3

  // table writes only while the select pin is high
  scc_table_mem #(
    .DEPTH   (TBL_DEPTH),
    .AW      (TBL_AW),
    .DW      (PT_W),
    .RST_VAL (TBL_RST_PT)
  ) u_scc_table_mem (
    .clk_in      (core_clk_in),
    .rst_in      (rst_in),
    .wr_en_in    (tbl_write_sel_in),     // R6
    .wr_addr_in  (tbl_wr_addr_in),
    .wr_data_in  (tbl_wr_data_in),
    .rd_addr_in  (decay_sel_in),
    .rd_data_out (decay_switch_point)    // R7
  );

  // strobe held until next tick so it is not lost between ticks;
  // a strobe on the tick edge is used at once and must not linger,
  // else the following tick would restart the cycle a second time
  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      strobe_pend_r <= 1'b0;
    end else if (osc_tick_in) begin
      strobe_pend_r <= 1'b0;
    end else if (strobe_in) begin
      strobe_pend_r <= 1'b1;              // R2
    end
  end

  // eight ticks per cycle; strobe clears at next tick
  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      cnt_r     <= 3'h0;
      restart_r <= 1'b0;
    end else if (osc_tick_in) begin
      if (strobe_pend_r || strobe_in) begin
        cnt_r     <= 3'h0;                // R2 R3
        restart_r <= 1'b1;
      end else begin
        cnt_r     <= inc3(cnt_r);         // R1 R12
        restart_r <= 1'b0;
      end
    end
  end

  // sample current at monitor point for next cycle
  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      skip_charge_r <= 1'b0;
    end else if (osc_tick_in && cnt_r == MON_PT) begin
      skip_charge_r <= set_point_reached_in &&
                       decay_mode_in != SCC_DM_SLOW;  // R11
    end
  end

  // blanking counter restarts on every mode change
  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      blank_r <= 4'h0;
    end else if (mode_nxt != mode_r) begin
      blank_r <= 4'(BLANK_N);
    end else if (blank_r != 4'h0) begin
      blank_r <= blank_r - 4'h1;
    end
  end

  // charge ends once set point reached outside blanking
  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      charge_done_r <= 1'b0;
    end else if (osc_tick_in &&
                 (cnt_r == MON_PT || strobe_pend_r || strobe_in)) begin
      charge_done_r <= 1'b0;
    end else if (mode_r == SCC_CHARGE && blank_r == 4'h0 &&
                 set_point_reached_in) begin
      charge_done_r <= 1'b1;              // R8
    end
  end

  always_comb begin
    mode_nxt = mode_r;
    if (oc_r) begin
      mode_nxt = SCC_OFF;                 // R9
    end else if (restart_r && cnt_r == 3'h0 && !charge_done_r) begin
      mode_nxt = SCC_CHARGE;              // R4
    end else begin
      case (decay_mode_in)
        SCC_DM_FAST: begin
          // momentary charge for the comparison at cycle start
          if (cnt_r == 3'h0 && !charge_done_r && !skip_charge_r) begin
            mode_nxt = SCC_CHARGE;        // R5
          end else begin
            mode_nxt = SCC_FAST;
          end
        end
        SCC_DM_MIXED: begin
          if (!charge_done_r && !skip_charge_r) begin
            mode_nxt = SCC_CHARGE;        // R10
          end else if (cnt_r < decay_switch_point) begin
            mode_nxt = SCC_SLOW;          // R10
          end else begin
            mode_nxt = SCC_FAST;          // R7
          end
        end
        default: begin
          mode_nxt = charge_done_r ? SCC_SLOW : SCC_CHARGE;
        end
      endcase
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      mode_r <= SCC_OFF;
    end else begin
      mode_r <= mode_nxt;
    end
  end

  // overcurrent must persist past the non-sensitivity ticks; latches
  // until reset since the bridge may be shorted
  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      oc_cnt_r <= 3'h0;
      oc_r     <= 1'b0;
    end else if (!overcurrent_in) begin
      oc_cnt_r <= 3'h0;
    end else if (osc_tick_in) begin
      if (oc_cnt_r == 3'(OC_MASK_TICKS)) begin
        oc_r <= 1'b1;                     // R9
      end else begin
        oc_cnt_r <= inc3(oc_cnt_r);
      end
    end
  end

  assign bridge_mode_out          = mode_r;
  assign chop_cnt_out             = cnt_r;
  assign overcurrent_shutdown_out = oc_r;

  a_strobe_clears: assert property (@(posedge core_clk_in) disable iff (rst_in)
    osc_tick_in && strobe_pend_r |=> cnt_r == 3'h0) // R2
    else $error("strobe did not clear counter");
  a_count_wraps: assert property (@(posedge core_clk_in) disable iff (rst_in)
    osc_tick_in && !strobe_in && !strobe_pend_r && cnt_r == 3'h7
    |=> cnt_r == 3'h0) // R12
    else $error("counter did not wrap");
  a_count_steps: assert property (@(posedge core_clk_in) disable iff (rst_in)
    !osc_tick_in |=> $stable(cnt_r)) // R1
    else $error("counter moved without tick");
  a_oc_off: assert property (@(posedge core_clk_in) disable iff (rst_in)
    oc_r |=> mode_r == SCC_OFF) // R9
    else $error("bridge on during shutdown");
  a_restart_charge: assert property (@(posedge core_clk_in)
    disable iff (rst_in)
    $rose(restart_r) && !oc_r && !charge_done_r && cnt_r == 3'h0
    |=> mode_r == SCC_CHARGE) // R4
    else $error("no charge after restart");
  a_blank_hold: assert property (@(posedge core_clk_in) disable iff (rst_in)
    mode_r == SCC_CHARGE && blank_r != 4'h0 && !osc_tick_in
    |=> !$rose(charge_done_r)) // R8
    else $error("comparator used during blanking");
  a_mixed_switch: assert property (@(posedge core_clk_in)
    disable iff (rst_in)
    decay_mode_in == SCC_DM_MIXED && !oc_r && !restart_r && charge_done_r
    && cnt_r >= decay_switch_point |=> mode_r == SCC_FAST) // R7
    else $error("no fast decay after switch point");
  a_skip_charge: assert property (@(posedge core_clk_in)
    disable iff (rst_in)
    decay_mode_in == SCC_DM_MIXED && skip_charge_r && !restart_r && !oc_r
    |=> mode_r != SCC_CHARGE) // R11
    else $error("charge not skipped");
  a_fast_charge: assert property (@(posedge core_clk_in)
    disable iff (rst_in)
    decay_mode_in == SCC_DM_FAST && !oc_r && cnt_r != 3'h0 && !restart_r
    |=> mode_r == SCC_FAST) // R5
    else $error("fast mode left fast decay");

  c_strobe: cover property (@(posedge core_clk_in) $rose(restart_r));
  c_fast: cover property (@(posedge core_clk_in) mode_r == SCC_FAST);
  c_oc: cover property (@(posedge core_clk_in) $rose(oc_r));
  c_skip: cover property (@(posedge core_clk_in) $rose(skip_charge_r));
endmodule : scc_chop_ctrl
`default_nettype wire

//--- tb/scc_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module scc_host_model (
  // clock
  input  wire logic        clk_in,
  // strobe and table load
  output var  logic        strobe_out,
  output var  logic        tbl_write_sel_out,
  output var  logic [1:0]  tbl_wr_addr_out,
  output var  logic [2:0]  tbl_wr_data_out
);
  initial begin
    strobe_out        = 1'h0;
    tbl_write_sel_out = 1'h0;
    tbl_wr_addr_out   = 2'h0;
    tbl_wr_data_out   = 3'h5;
  end

  task automatic pulse_strobe();
    @(posedge clk_in) strobe_out <= 1'h1;
    @(posedge clk_in) strobe_out <= 1'h0;
  endtask : pulse_strobe

  // data is garbled once select drops, so a late read cannot pass
  task automatic write_table(input logic [1:0] a, input logic [2:0] d);
    @(posedge clk_in) tbl_write_sel_out <= 1'h1;
    tbl_wr_addr_out <= a;
    tbl_wr_data_out <= d;
    @(posedge clk_in) tbl_write_sel_out <= 1'h0;
    tbl_wr_data_out <= ~d;
  endtask : write_table
endmodule : scc_host_model
`default_nettype wire

//--- tb/stepper_chop_control_tb.sv
`timescale 1ns/1ps
`default_nettype none
module stepper_chop_control_tb;
  import scc_pkg::*;
  logic       core_clk_in = 1'h0;
  logic       rst_in      = 1'h1;
  logic       osc_tick    = 1'h0;
  logic       set_pt      = 1'h0;
  logic       over_cur    = 1'h0;
  scc_dmode_t dmode       = SCC_DM_MIXED;
  logic [1:0] dsel        = 2'h0;
  logic       strobe, wr_sel, shut;
  logic [1:0] wr_addr;
  logic [2:0] wr_data, cnt, cnt_e, pt;
  logic [3:0] div;
  scc_mode_t  mode;
  int         error_cnt   = 0;
  int         n_checks    = 0;

  always #50 core_clk_in = ~core_clk_in;
  // oscillator: one tick every ten clocks, held off in reset
  always @(posedge core_clk_in) begin
    div      <= (rst_in || div == 4'h9) ? 4'h0 : div + 4'h1;
    osc_tick <= !rst_in && div == 4'h9;
  end

  scc_host_model u_scc_host_model (
    .clk_in(core_clk_in), .strobe_out(strobe),
    .tbl_write_sel_out(wr_sel), .tbl_wr_addr_out(wr_addr),
    .tbl_wr_data_out(wr_data));

  scc_chop_ctrl u_scc_chop_ctrl (
    .core_clk_in(core_clk_in), .rst_in(rst_in),
    .osc_tick_in(osc_tick), .strobe_in(strobe),
    .decay_mode_in(dmode), .decay_sel_in(dsel),
    .tbl_write_sel_in(wr_sel), .tbl_wr_addr_in(wr_addr),
    .tbl_wr_data_in(wr_data), .set_point_reached_in(set_pt),
    .overcurrent_in(over_cur), .bridge_mode_out(mode),
    .chop_cnt_out(cnt), .overcurrent_shutdown_out(shut));

  task automatic chk_mode(input string w, input scc_mode_t e,
                          input scc_mode_t g);
    n_checks++;
    if (g !== e) begin
      error_cnt++;
      $display("[ERR] %s expected %0d seen %0d", w, e, g);
    end
  endtask : chk_mode

  task automatic chk_num(input string w, input logic [2:0] e,
                         input logic [2:0] g);
    n_checks++;
    if (g !== e) begin
      error_cnt++;
      $display("[ERR] %s expected %0d seen %0d", w, e, g);
    end
  endtask : chk_num

  // returns just after the edge that took a tick
  task automatic wait_tick();
    do @(posedge core_clk_in); while (osc_tick !== 1'h1);
    #1;
    cnt_e = cnt_e + 3'h1;
  endtask : wait_tick

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : end_of_test

  initial begin
    // about 1200 clocks of tests, with margin
    repeat (20000) @(posedge core_clk_in);
    error_cnt++;
    end_of_test();
  end

  initial begin
    void'($urandom(17890));
    repeat (12) @(posedge core_clk_in);
    #1;
    chk_mode("mode in reset", SCC_OFF, mode);
    chk_num("count in reset", 3'h0, cnt);
    @(posedge core_clk_in) rst_in <= 1'h0;
    cnt_e = 3'h0;
    repeat (16) begin
      wait_tick();
      chk_num("count", cnt_e, cnt);
    end
    $display("done: counting");
    repeat (4) begin
      repeat ($urandom % 8) @(posedge core_clk_in);
      u_scc_host_model.pulse_strobe();
      wait_tick();
      chk_num("count after strobe", 3'h0, cnt);
    end
    // corner: strobe sampled on the very tick edge
    repeat (8) @(posedge core_clk_in);
    u_scc_host_model.pulse_strobe();
    #1;
    chk_num("strobe on tick", 3'h0, cnt);
    wait_tick();
    chk_num("single restart", 3'h1, cnt);
    cnt_e = 3'h1;
    $display("done: strobe");
    @(posedge core_clk_in) set_pt <= 1'h1;
    for (int i = 0; i < 4; i++) begin
      pt = 3'h1 + 3'($urandom % 7);
      u_scc_host_model.write_table(2'(i), pt);
      dsel <= 2'(i);
      repeat (8) wait_tick();
      repeat (8) begin
        wait_tick();
        repeat (5) @(posedge core_clk_in);
        #1;
        chk_mode("mixed", (cnt_e >= pt) ? SCC_FAST : SCC_SLOW, mode);
      end
    end
    $display("done: mixed decay");
    // let slow mode finish its charge so the restart is a real change
    @(posedge core_clk_in) dmode <= SCC_DM_SLOW;
    repeat (8) @(posedge core_clk_in);
    set_pt <= 1'h0;
    u_scc_host_model.pulse_strobe();
    wait_tick();
    @(posedge core_clk_in);
    #1;
    chk_mode("charge after restart", SCC_CHARGE, mode);
    @(posedge core_clk_in) set_pt <= 1'h1;
    @(posedge core_clk_in);
    @(posedge core_clk_in) set_pt <= 1'h0;
    repeat (2) @(posedge core_clk_in);
    #1;
    chk_mode("charge under blanking", SCC_CHARGE, mode);
    @(posedge core_clk_in) set_pt <= 1'h1;
    repeat (6) @(posedge core_clk_in);
    #1;
    chk_mode("slow after charge", SCC_SLOW, mode);
    $display("done: blanking");
    @(posedge core_clk_in) dmode <= SCC_DM_FAST;
    set_pt <= 1'h0;
    do wait_tick(); while (cnt !== 3'h0);
    @(posedge core_clk_in);
    #1;
    chk_mode("fast cycle start", SCC_CHARGE, mode);
    @(posedge core_clk_in) set_pt <= 1'h1;
    repeat (6) @(posedge core_clk_in);
    #1;
    chk_mode("fast after charge", SCC_FAST, mode);
    $display("done: fast decay");
    @(posedge core_clk_in) over_cur <= 1'h1;
    repeat (2) wait_tick();
    @(posedge core_clk_in) over_cur <= 1'h0;
    repeat (6) wait_tick();
    chk_num("brief overcurrent", 3'h0, {2'h0, shut});
    @(posedge core_clk_in) over_cur <= 1'h1;
    repeat (9) wait_tick();
    chk_num("shutdown", 3'h1, {2'h0, shut});
    chk_mode("bridge off", SCC_OFF, mode);
    @(posedge core_clk_in) rst_in <= 1'h1;
    over_cur <= 1'h0;
    repeat (2) @(posedge core_clk_in);
    #1;
    chk_num("shutdown cleared", 3'h0, {2'h0, shut});
    $display("done: overcurrent");
    end_of_test();
  end
endmodule : stepper_chop_control_tb
`default_nettype wire
